// ### dbt_top.sv
// debug event comparators, break control and trace recorder
`include "dbt_defines.svh"
`default_nettype none
module dbt_top
   import dbt_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        acc_valid,
   input  wire logic [23:0] acc_addr,
   input  wire logic        acc_write,
   input  wire logic        acc_word,
   input  wire logic [15:0] acc_data,
   input  wire logic        br_valid,
   input  wire logic [23:0] br_src,
   input  wire logic [23:0] br_dst,
   input  wire logic [15:0] instruction_counter_value,
   input  wire logic        prog_start,
   input  wire logic        prog_stop,
   output logic             break_req,
   output logic             trace_active
);
   // ==========================================================
   // register bus
   logic [23:0] a_addr_reg, b_addr_reg;
   logic [9:0]  a_cfg_reg, b_cfg_reg;
   logic [31:0] a_data_reg;
   logic [11:0] ctl_reg;
   logic [7:0]  index_reg;
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_mux;
   logic [31:0] be_mask;
   logic        wr_fire;
   logic        rd_take;
   logic [31:0] status_w;
   logic [57:0] mem_rdata;
   logic [31:0] wr_word;

   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // a write lands only at the edge where waitrequest is seen low
   assign wr_fire = avs_write && !wait_reg;
   assign rd_take = (avs_read || avs_write) && wait_reg;

   // unmasked lanes keep what a read of the same address shows
   assign wr_word = (rd_mux & ~be_mask) | (avs_writedata & be_mask);

   always_comb begin
      unique case (avs_address)
         `DBT_OFS_A_ADDR: rd_mux = {8'h00, a_addr_reg};
         `DBT_OFS_A_CFG:  rd_mux = {22'h000000, a_cfg_reg};
         `DBT_OFS_B_ADDR: rd_mux = {8'h00, b_addr_reg};
         `DBT_OFS_B_CFG:  rd_mux = {22'h000000, b_cfg_reg};
         `DBT_OFS_A_DATA: rd_mux = a_data_reg;
         `DBT_OFS_CTRL:   rd_mux = {20'h00000, ctl_reg};
         `DBT_OFS_STATUS: rd_mux = status_w;
         `DBT_OFS_INDEX:  rd_mux = {24'h000000, index_reg};
         `DBT_OFS_ENT_LO: rd_mux = mem_rdata[31:0];
         `DBT_OFS_ENT_HI: rd_mux = {6'h00, mem_rdata[57:32]};
         default:         rd_mux = 32'h00000000;
      endcase
   end

   // one wait cycle for every access, unmapped ones included
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else if (ce) begin
         wait_reg <= !rd_take;
         if (rd_take && avs_read) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         a_addr_reg <= 24'h000000;
         b_addr_reg <= 24'h000000;
         a_cfg_reg  <= `DBT_CFG_RST;
         b_cfg_reg  <= `DBT_CFG_RST;
         a_data_reg <= 32'h00000000;
         ctl_reg    <= `DBT_CTL_RST;
         index_reg  <= 8'h00;
      end else if (ce && wr_fire) begin
         unique case (avs_address)
            `DBT_OFS_A_ADDR: a_addr_reg <= wr_word[23:0];
            `DBT_OFS_A_CFG:  a_cfg_reg  <= wr_word[9:0];
            `DBT_OFS_B_ADDR: b_addr_reg <= wr_word[23:0];
            `DBT_OFS_B_CFG:  b_cfg_reg  <= wr_word[9:0];
            `DBT_OFS_A_DATA: a_data_reg <= wr_word;
            `DBT_OFS_CTRL:   ctl_reg    <= wr_word[11:0];
            `DBT_OFS_INDEX:  index_reg  <= wr_word[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // event comparators
   logic [23:0] a_keep, b_keep;
   logic        a_qual, b_qual, a_dhit;
   logic        ev_a, ev_b;

   assign a_keep = 24'hFFFFFF << a_cfg_reg[`DBT_CFG_MASK];
   assign b_keep = 24'hFFFFFF << b_cfg_reg[`DBT_CFG_MASK];

   // access fields are arguments so the callers' assigns see them change
   function automatic logic qual(input logic [9:0] cfg, input logic word,
                                 input logic wr);
      dbt_size_t sz;
      dbt_dir_t  dr;
      sz = dbt_size_t'(cfg[`DBT_CFG_SIZE]);
      dr = dbt_dir_t'(cfg[`DBT_CFG_DIR]);
      qual = cfg[`DBT_CFG_EN]
         && (sz == DBT_SZ_ANY || (sz == DBT_SZ_WORD) == word)
         && (dr == DBT_DIR_RW || (dr == DBT_DIR_WRITE) == wr);
   endfunction : qual

   assign a_qual = qual(a_cfg_reg, acc_word, acc_write);
   assign b_qual = qual(b_cfg_reg, acc_word, acc_write);
   // zero data mask means no data compare on event A
   assign a_dhit = ((acc_data ^ a_data_reg[15:0]) & a_data_reg[31:16])
                   == 16'h0000;
   assign ev_a = acc_valid && a_qual && a_dhit
                 && ((acc_addr ^ a_addr_reg) & a_keep) == 24'h000000;
   // address only, data never looked at
   assign ev_b = acc_valid && b_qual
                 && ((acc_addr ^ b_addr_reg) & b_keep) == 24'h000000;

   // ==========================================================
   // sticky seen flags and combined conditions
   logic a_seen_reg, b_seen_reg, seq_seen_reg;
   logic both_now, seq_now;

   // the order flag needs B strictly before A: same-cycle pair is no order
   assign seq_now  = ev_a && b_seen_reg;
   assign both_now = (ev_a || a_seen_reg) && (ev_b || b_seen_reg);

   // set wins over the clear done by a program start
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         a_seen_reg   <= 1'b0;
         b_seen_reg   <= 1'b0;
         seq_seen_reg <= 1'b0;
      end else if (ce) begin
         a_seen_reg   <= ev_a || (a_seen_reg && !prog_start);
         b_seen_reg   <= ev_b || (b_seen_reg && !prog_start);
         seq_seen_reg <= seq_now || (seq_seen_reg && !prog_start);
      end
   end

   // one bit per condition code; none and the unused codes stay low
   logic [7:0] cond_vec;
   assign cond_vec = {3'h0, seq_now, both_now, ev_a || ev_b, ev_a, 1'h0};

   // ==========================================================
   // break control
   dbt_cond_t brk_sel, start_sel, stop_sel;
   logic      full_brk, brk_hit, full_w;
   logic      break_reg;

   assign brk_sel   = dbt_cond_t'(ctl_reg[`DBT_CTL_BRK]);
   assign start_sel = dbt_cond_t'(ctl_reg[`DBT_CTL_START]);
   assign stop_sel  = dbt_cond_t'(ctl_reg[`DBT_CTL_STOP]);
   assign full_brk  = ctl_reg[`DBT_CTL_FULLBRK];
   // none selects a low bit, so only full can break then
   assign brk_hit = cond_vec[brk_sel]
                    || (full_brk && full_w);

   // break request holds until the core starts the program again
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         break_reg <= 1'b0;
      end else if (ce) begin
         break_reg <= brk_hit || (break_reg && !prog_start);
      end
   end
   assign break_req = break_reg;

   // ==========================================================
   // trace start and stop
   logic tracing_reg, done_reg;
   logic start_ev, stop_ev;

   // done keeps a level condition such as A-and-B from restarting
   assign start_ev = (start_sel == DBT_COND_NONE) ? prog_start
      : (!tracing_reg && !done_reg && cond_vec[start_sel]);
   always_comb begin
      unique case (stop_sel)
         DBT_COND_NONE: stop_ev = prog_stop;
         DBT_COND_FULL: stop_ev = full_w;
         default:       stop_ev = cond_vec[stop_sel];
      endcase
   end

   // tracing is registered, so the access firing a start is not stored
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tracing_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else if (ce) begin
         if (start_ev) begin
            tracing_reg <= 1'b1;
         end else if (stop_ev && tracing_reg) begin
            tracing_reg <= 1'b0;
         end
         done_reg <= (stop_ev && tracing_reg && !start_ev)
                     || (done_reg && !prog_start);
      end
   end
   assign trace_active = tracing_reg;

   // ==========================================================
   // trace recording
   logic        data_mode, pick_ab, pick_hit;
   logic        pend_reg;
   logic [23:0] pend_dst_reg;
   logic [7:0]  wp_reg;
   logic [8:0]  count_reg;
   logic        mem_we;
   logic [57:0] mem_wdata;
   logic [23:0] ev_addr;
   logic [7:0]  rd_addr;

   assign data_mode = ctl_reg[`DBT_CTL_TYPE];
   assign pick_ab   = ctl_reg[`DBT_CTL_PICK];
   assign pick_hit  = ev_a || (pick_ab && ev_b);
   assign full_w    = count_reg == `DBT_DEPTH;
   // the event's programmed range is stored, A taking precedence
   assign ev_addr = ev_a ? (a_addr_reg & a_keep)
                         : (b_addr_reg & b_keep);
   // with stop on full, a pending destination may not overwrite the oldest entry either
   assign mem_we = !(stop_sel == DBT_COND_FULL && full_w)
      && (data_mode ? (tracing_reg && acc_valid && pick_hit)
                    : (pend_reg || (tracing_reg && br_valid)));

   // entry: type, kind, address, data, instruction counter
   always_comb begin
      if (data_mode) begin
         mem_wdata = {1'b1, acc_write, ev_addr, acc_data,
                      instruction_counter_value};
      end else if (pend_reg) begin
         mem_wdata = {1'b0, 1'b1, pend_dst_reg, 16'h0000,
                      instruction_counter_value};
      end else begin
         mem_wdata = {1'b0, 1'b0, br_src, 16'h0000,
                      instruction_counter_value};
      end
   end

   // one write port: a destination goes in the cycle after its source,
   // so a branch arriving in that cycle is dropped
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pend_reg     <= 1'b0;
         pend_dst_reg <= 24'h000000;
      end else if (ce) begin
         pend_reg <= mem_we && !data_mode && !pend_reg;
         if (br_valid && !pend_reg) begin
            pend_dst_reg <= br_dst;
         end
      end
   end

   // ring buffer: count saturates, oldest entries are overwritten
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wp_reg    <= 8'h00;
         count_reg <= 9'h000;
      end else if (ce) begin
         if (prog_start) begin
            wp_reg    <= 8'h00;
            count_reg <= 9'h000;
         end else if (mem_we) begin
            wp_reg <= wp_reg + 8'h01;
            if (!full_w) begin
               count_reg <= count_reg + 9'h001;
            end
         end
      end
   end

   // index 0 is the newest entry, counting back from the write pointer
   assign rd_addr = wp_reg - 8'h01 - index_reg;

   dbt_trace_mem u_mem (
      .clock (clock),
      .ce    (ce),
      .we    (mem_we),
      .waddr (wp_reg),
      .wdata (mem_wdata),
      .raddr (rd_addr),
      .rdata (mem_rdata)
   );

   assign status_w = {14'h0000, count_reg, 2'h0, pend_reg,
                      seq_seen_reg, b_seen_reg, a_seen_reg, full_w,
                      break_reg, tracing_reg};
   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_mask;
      ev_a |-> (acc_addr >> a_cfg_reg[`DBT_CFG_MASK])
               == (a_addr_reg >> a_cfg_reg[`DBT_CFG_MASK]);
   endproperty
   a_mask: assert property (p_mask) else $error("mask");
   property p_size;
      ev_b && b_cfg_reg[`DBT_CFG_SIZE] == DBT_SZ_BYTE |-> !acc_word;
   endproperty
   a_size: assert property (p_size) else $error("size");
   property p_none;
      ce && brk_sel == DBT_COND_NONE && !full_brk && !break_reg
         |=> !break_reg;
   endproperty
   a_none: assert property (p_none) else $error("none break");
   property p_brk_a;
      ce && brk_sel == DBT_COND_A && ev_a |=> break_reg;
   endproperty
   a_brk_a: assert property (p_brk_a) else $error("break A");
   property p_seq;
      ce && brk_sel == DBT_COND_SEQ && ev_a && b_seen_reg |=> break_reg;
   endproperty
   a_seq: assert property (p_seq) else $error("seq break");
   property p_full;
      ce && full_brk && full_w |=> break_reg;
   endproperty
   a_full: assert property (p_full) else $error("full break");
   property p_go;
      ce && start_sel == DBT_COND_NONE && prog_start |=> tracing_reg;
   endproperty
   a_go: assert property (p_go) else $error("go start");
   property p_ign;
      ce && start_ev && stop_ev |=> tracing_reg;
   endproperty
   a_ign: assert property (p_ign) else $error("stop kept");
   property p_rec;
      mem_we |-> tracing_reg || pend_reg;
   endproperty
   a_rec: assert property (p_rec) else $error("early record");
   property p_cnt;
      ce && mem_we && !full_w && !prog_start
         |=> count_reg == $past(count_reg) + 9'h001;
   endproperty
   a_cnt: assert property (p_cnt) else $error("count");
   c_seq: cover property (ce && brk_sel == DBT_COND_SEQ && seq_now);
   c_full: cover property (ce && full_w && tracing_reg);
   c_data: cover property (ce && mem_we && data_mode);
   c_pair: cover property (ce && mem_we && pend_reg);
endmodule : dbt_top
`default_nettype wire

// ### dbt_defines.svh
// offsets, field positions and reset values of the debug event block
// Overview of operation
// - event B compares a masked address only, never data
// - event B uses the same mask, size and direction qualifiers as A
// - break selection none never halts the program on events
// - break selection A halts on an event A match
// - break selection A-or-B halts on either match
// - break selection A-and-B halts once both have been seen
// - sequential selection halts on A after an earlier B
// - trace-full break halts once the buffer is full, beside event break
// - trace type selects branch trace or data trace
// - start selection go starts recording when the program starts
// - recording may also start on A, A-or-B, A-and-B, B-then-A
// - stop selection break ends recording when the program stops
// - stop selection full ends recording when the buffer fills
// - recording may also stop on A, A-or-B, A-and-B, B-then-A
// - data trace pick-up A records only A matches
// - data trace pick-up A-or-B records A or B matches
// - entries indexed from the end, newest at index 0
// - branch trace stores a source entry then a destination entry
// - data entry holds direction and transferred data
// - data entry holds the matching event's masked address
// - the programmed number of low address bits is ignored
// - no event when access width differs from size qualifier
// - access that fires an event start is not itself recorded
// - simultaneous start and stop ignores the stop
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH
`define DBT_OFS_A_ADDR   8'h00
`define DBT_OFS_A_CFG    8'h04
`define DBT_OFS_B_ADDR   8'h08
`define DBT_OFS_B_CFG    8'h0C
`define DBT_OFS_A_DATA   8'h10
`define DBT_OFS_CTRL     8'h14
`define DBT_OFS_STATUS   8'h18
`define DBT_OFS_INDEX    8'h1C
`define DBT_OFS_ENT_LO   8'h20
`define DBT_OFS_ENT_HI   8'h24
// event config fields
`define DBT_CFG_MASK     4:0
`define DBT_CFG_SIZE     6:5
`define DBT_CFG_DIR      8:7
`define DBT_CFG_EN       9
// control fields
`define DBT_CTL_BRK      2:0
`define DBT_CTL_FULLBRK  3
`define DBT_CTL_TYPE     4
`define DBT_CTL_START    7:5
`define DBT_CTL_STOP     10:8
`define DBT_CTL_PICK     11
`define DBT_DEPTH        9'h100
`define DBT_CFG_RST      10'h000
`define DBT_CTL_RST      12'h000
`endif

// ### dbt_pkg.sv
// types shared by the debug event block
`default_nettype none
package dbt_pkg;
   typedef enum logic [2:0] {
      DBT_COND_NONE = 3'h0,
      DBT_COND_A    = 3'h1,
      DBT_COND_OR   = 3'h2,
      DBT_COND_AND  = 3'h3,
      DBT_COND_SEQ  = 3'h4,
      DBT_COND_FULL = 3'h5
   } dbt_cond_t;
   typedef enum logic [1:0] {
      DBT_SZ_ANY  = 2'h0,
      DBT_SZ_BYTE = 2'h1,
      DBT_SZ_WORD = 2'h2
   } dbt_size_t;
   typedef enum logic [1:0] {
      DBT_DIR_RW    = 2'h0,
      DBT_DIR_READ  = 2'h1,
      DBT_DIR_WRITE = 2'h2
   } dbt_dir_t;
endpackage : dbt_pkg
`default_nettype wire

// ### dbt_trace_mem.sv
// trace buffer memory with registered read data
`default_nettype none
module dbt_trace_mem (
   input  wire logic        clock,
   input  wire logic        ce,
   input  wire logic        we,
   input  wire logic [7:0]  waddr,
   input  wire logic [57:0] wdata,
   input  wire logic [7:0]  raddr,
   output var  logic [57:0] rdata
);
   logic [57:0] mem [0:255];

   always_ff @(posedge clock) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
      if (ce) begin
         rdata <= mem[raddr];
      end
   end
endmodule : dbt_trace_mem
`default_nettype wire

// ### dbt_core_model.sv
// core model: data accesses, branches and run control pulses
`default_nettype none
module dbt_core_model (
   input  wire logic        clock,
   output logic             acc_valid,
   output logic      [23:0] acc_addr,
   output logic             acc_write,
   output logic             acc_word,
   output logic      [15:0] acc_data,
   output logic             br_valid,
   output logic      [23:0] br_src,
   output logic      [23:0] br_dst,
   output logic      [15:0] instruction_counter_value,
   output logic             prog_start,
   output logic             prog_stop
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // idle state and free running counter
   initial begin
      {acc_valid, acc_write, acc_word, br_valid} = 4'h0;
      {acc_addr, br_src, br_dst} = 72'h0;
      {acc_data, instruction_counter_value} = 32'h0;
      {prog_start, prog_stop} = 2'h0;
   end
   always @(posedge clock) begin
      instruction_counter_value <= instruction_counter_value + 16'h0001;
   end
   // ==========
   // stimulus tasks, each starts one edge on so pulses never collide
   task automatic access(input logic [23:0] a, input logic w,
                         input logic wd, input logic [15:0] d,
                         input int gap);
      @(posedge clock);
      acc_valid <= 1'b1;
      acc_addr  <= a;
      acc_write <= w;
      acc_word  <= wd;
      acc_data  <= d;
      @(posedge clock);
      acc_valid <= 1'b0;
      // released lines carry junk so a stale value is never reused
      acc_addr  <= ~a;
      acc_data  <= ~d;
      repeat (gap) @(posedge clock);
   endtask : access
   task automatic branch(input logic [23:0] s, input logic [23:0] t);
      @(posedge clock);
      br_valid <= 1'b1;
      br_src   <= s;
      br_dst   <= t;
      @(posedge clock);
      br_valid <= 1'b0;
      br_src   <= ~s;
      br_dst   <= ~t;
   endtask : branch
   task automatic run_ctl(input logic go);
      @(posedge clock);
      prog_start <= go;
      prog_stop  <= !go;
      @(posedge clock);
      prog_start <= 1'b0;
      prog_stop  <= 1'b0;
   endtask : run_ctl
endmodule : dbt_core_model
`default_nettype wire

// ### dbt_top_test.sv
// self-checking bench for the debug event, break and trace block
`include "dbt_defines.svh"
`default_nettype none
module dbt_top_test import dbt_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 20000;
   logic        clock, arst_n, ce, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd_q;
   logic [3:0]  avs_byteenable;
   logic        acc_valid, acc_write, acc_word, br_valid;
   logic [23:0] acc_addr, br_src, br_dst;
   logic [15:0] acc_data, instruction_counter_value;
   logic        prog_start, prog_stop, break_req, trace_active;
   int          errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   // access kinds: A hit, B hit, miss, six near misses, then a B hit at the range base
   logic [23:0] ad [10] = '{24'h000420, 24'h000403, 24'h0007FF,
      24'h000404, 24'h000421, 24'h000420, 24'h000400, 24'h000400,
      24'h000420, 24'h000400};
   logic [9:0]  wr_v = 10'h071;
   logic [9:0]  wd_v = 10'h191;
   // row nibbles: break code, first access, second access, halt
   logic [15:0] rows [11] = '{16'h0010, 16'h1021, 16'h1110, 16'h2921,
      16'h2340, 16'h2560, 16'h2780, 16'h3020, 16'h3011, 16'h4010,
      16'h4101};

   dbt_top dut (.clock(clock), .arst_n(arst_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_write(acc_write), .acc_word(acc_word),
      .acc_data(acc_data), .br_valid(br_valid), .br_src(br_src),
      .br_dst(br_dst),
      .instruction_counter_value(instruction_counter_value),
      .prog_start(prog_start), .prog_stop(prog_stop),
      .break_req(break_req), .trace_active(trace_active));
   dbt_core_model core (.clock(clock), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_write(acc_write), .acc_word(acc_word),
      .acc_data(acc_data), .br_valid(br_valid), .br_src(br_src),
      .br_dst(br_dst),
      .instruction_counter_value(instruction_counter_value),
      .prog_start(prog_start), .prog_stop(prog_stop));

   // ==========
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors = errors + 1;
         close_out();
      end
   end
   // ==========
   // helpers
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask : check
   task automatic flag(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask : flag
   // held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be = 4'hF);
      @(posedge clock);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= w;
      avs_read       <= ~w;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic trig(input logic [3:0] k, input logic [15:0] d,
                       input int gap);
      core.access(ad[k], wr_v[k], wd_v[k], d, gap);
   endtask : trig
   task automatic ent(input logic [7:0] idx, input logic [31:0] hi,
                      input logic use_d, input logic [15:0] dat);
      logic [31:0] h;
      wr(`DBT_OFS_INDEX, {24'h0, idx});
      rd(`DBT_OFS_ENT_HI);
      h = rd_q;
      rd(`DBT_OFS_ENT_LO);
      check(h, hi);
      if (use_d) check({16'h0, rd_q[31:16]}, {16'h0, dat});
   endtask : ent
   task automatic count_is(input logic [8:0] n);
      rd(`DBT_OFS_STATUS);
      check({23'h0, rd_q[17:9]}, {23'h0, n});
   endtask : count_is
   // ==========
   // main sequence
   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      {avs_read, avs_write} = 2'h0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      rd(`DBT_OFS_CTRL);
      check(rd_q, {20'h0, `DBT_CTL_RST});
      rd(`DBT_OFS_A_CFG);
      check(rd_q, {22'h0, `DBT_CFG_RST});
      wr(8'h30, 32'hFFFF_FFFF);
      rd(8'h30);
      check(rd_q, 32'h0);
      // upper lanes carry junk that the byte enables must keep out
      bus(1'b1, `DBT_OFS_A_ADDR, 32'hFFFF_0420, 4'h3);
      rd(`DBT_OFS_A_ADDR);
      check(rd_q, 32'h0000_0420);
      wr(`DBT_OFS_A_CFG, 32'h0000_0340);
      wr(`DBT_OFS_A_DATA, 32'h0000_0000);
      wr(`DBT_OFS_B_ADDR, 32'h0000_0400);
      wr(`DBT_OFS_B_CFG, 32'h0000_02A2);
      for (int i = 0; i < 11; i++) begin
         wr(`DBT_OFS_CTRL, {29'h0, rows[i][14:12]});
         core.run_ctl(1'b1);
         trig(rows[i][11:8], 16'h5A5A, i % 3);
         trig(rows[i][7:4], 16'hA5A5, 0);
         repeat (3) @(posedge clock);
         flag(break_req, rows[i][0]);
         core.run_ctl(1'b0);
      end
      // clock enable low: an event A hit must not raise a break request
      wr(`DBT_OFS_CTRL, 32'h0000_0001);
      core.run_ctl(1'b1);
      ce <= !ce;
      trig(4'h0, 16'h0000, 2);
      ce <= !ce;
      repeat (2) @(posedge clock);
      flag(break_req, 1'b0);
      // branch trace from program start to program stop
      wr(`DBT_OFS_CTRL, 32'h0);
      core.run_ctl(1'b1);
      repeat (2) @(posedge clock);
      flag(trace_active, 1'b1);
      core.branch(24'h001234, 24'h005678);
      core.branch(24'h00ABCD, 24'h00EF01);
      core.run_ctl(1'b0);
      repeat (2) @(posedge clock);
      flag(trace_active, 1'b0);
      ent(8'h00, 32'h0100_EF01, 1'b0, 16'h0);
      ent(8'h01, 32'h0000_ABCD, 1'b0, 16'h0);
      ent(8'h02, 32'h0100_5678, 1'b0, 16'h0);
      // data trace started by A, picking up A or B
      wr(`DBT_OFS_CTRL, 32'h0000_0830);
      core.run_ctl(1'b1);
      repeat (2) @(posedge clock);
      flag(trace_active, 1'b0);
      trig(4'h0, 16'h1111, 2);
      flag(trace_active, 1'b1);
      trig(4'h1, 16'h2222, 0);
      trig(4'h2, 16'h7777, 0);
      trig(4'h0, 16'h3333, 2);
      count_is(9'h002);
      ent(8'h00, 32'h0300_0420, 1'b1, 16'h3333);
      ent(8'h01, 32'h0200_0400, 1'b1, 16'h2222);
      // pick-up A only, stop on A
      wr(`DBT_OFS_CTRL, 32'h0000_0110);
      core.run_ctl(1'b1);
      trig(4'h1, 16'h4444, 2);
      flag(trace_active, 1'b1);
      count_is(9'h000);
      trig(4'h0, 16'h5555, 2);
      flag(trace_active, 1'b0);
      // start and stop on the same access: stop is ignored
      wr(`DBT_OFS_CTRL, 32'h0000_0130);
      core.run_ctl(1'b1);
      trig(4'h0, 16'h6666, 2);
      flag(trace_active, 1'b1);
      // fill the buffer: stop on full and halt on full
      wr(`DBT_OFS_CTRL, 32'h0000_0508);
      core.run_ctl(1'b1);
      for (int i = 0; i < 127; i++) begin
         core.branch(24'h000100 + 24'(i), 24'h000300 + 24'(i));
      end
      repeat (3) @(posedge clock);
      flag(break_req, 1'b0);
      flag(trace_active, 1'b1);
      core.branch(24'h000FFF, 24'h000EEE);
      repeat (3) @(posedge clock);
      flag(break_req, 1'b1);
      flag(trace_active, 1'b0);
      count_is(`DBT_DEPTH);
      flag(rd_q[2], 1'b1);
      // reset in mid-run clears outputs at once
      @(posedge clock);
      arst_n <= 1'b0;
      @(posedge clock);
      flag(break_req, 1'b0);
      flag(trace_active, 1'b0);
      flag(avs_waitrequest, 1'b1);
      arst_n <= 1'b1;
      rd(`DBT_OFS_STATUS);
      check(rd_q, 32'h0);
      close_out();
   end
endmodule : dbt_top_test
`default_nettype wire
